// ### design/pefs_pkg.sv
// Constants, register map and types for the upper port E pin mux
package pefs_pkg;
  // Register bus shape
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // Pins 16..24 map to index 0..8
  localparam int NPINS = 9;
  localparam int SEL_W = 2;
  localparam int TOP_PIN_IDX = 8;
  localparam int NFIELDS = DATA_W / SEL_W;
  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_TOP_SEL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_HIGH_SEL = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_DIR = 4'h4;
  // Writable bit masks; other bits read as zero
  localparam logic [DATA_W-1:0] TOP_SEL_MASK = 16'h0003;
  localparam logic [DATA_W-1:0] HIGH_SEL_MASK = 16'hffff;
  localparam logic [DATA_W-1:0] DIR_MASK = 16'h01ff;
  // Reset values and host boot values
  localparam logic [DATA_W-1:0] TOP_SEL_RST = 16'h0000;
  localparam logic [DATA_W-1:0] HIGH_SEL_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DIR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] TOP_SEL_BOOT = 16'h0001;
  localparam logic [DATA_W-1:0] HIGH_SEL_BOOT = 16'h5555;
  localparam logic [DATA_W-1:0] READ_IDLE = 16'h0000;
  // Selector codes
  localparam logic [SEL_W-1:0] SEL_PORT = 2'h0;
  localparam logic [SEL_W-1:0] SEL_HOST = 2'h1;
  localparam logic [SEL_W-1:0] SEL_SERIAL = 2'h2;
  localparam logic [SEL_W-1:0] SEL_BAD = 2'h3;
  // Pins whose serial function may drive the pad
  localparam logic [NPINS-1:0] SER_DRIVE_MASK = 9'h0b6;
  // Width of the input synchroniser (pins plus boot strap)
  localparam int SYNC_W = NPINS + 1;
  // Start-up sequence that captures the boot strap
  typedef enum logic [1:0] {
    ST_WAIT0 = 2'h0,
    ST_WAIT1 = 2'h1,
    ST_LOAD = 2'h3,
    ST_RUN = 2'h2
  } pefs_state_t;
endpackage : pefs_pkg

// ### design/pefs_sync.sv
// Two-flop synchroniser for pad and strap inputs
`timescale 1ns/1ps
`default_nettype none
module pefs_sync
  import pefs_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  // First stage, read only by the second
  logic [W-1:0] meta;

  // Both stages clear to zero under reset
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : pefs_sync
`default_nettype wire

// ### design/pefs_pin_cell.sv
// Registered routing cell for one multiplexed pad
`timescale 1ns/1ps
`default_nettype none
module pefs_pin_cell
  import pefs_pkg::*;
#(
  parameter logic SER_CAN_DRIVE = 1'b0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [SEL_W-1:0] sel,
  input wire logic dir,
  input wire logic pad_sync,
  input wire logic gpio_out,
  input wire logic host_out,
  input wire logic host_oe,
  input wire logic ser_out,
  input wire logic ser_oe,
  output logic pad_out,
  output logic pad_oe_n,
  output logic gpio_in,
  output logic host_in,
  output logic ser_in
);
  // Pad drive and enable follow the selected function
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pad_out <= 1'b0;
      pad_oe_n <= 1'b1;
    end
    else
    begin
      case (sel)
        SEL_PORT:
        begin
          pad_out <= gpio_out;
          pad_oe_n <= ~dir;
        end
        SEL_HOST:
        begin
          pad_out <= host_out;
          pad_oe_n <= ~host_oe;
        end
        SEL_SERIAL:
        begin
          // Input-only serial functions never get the pad
          pad_out <= ser_out;
          pad_oe_n <= ~(ser_oe & SER_CAN_DRIVE);
        end
        default:
        begin
          // Never two drivers: release the pad
          pad_out <= 1'b0;
          pad_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // Only the selected function sees the pad; others read zero
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gpio_in <= 1'b0;
      host_in <= 1'b0;
      ser_in <= 1'b0;
    end
    else
    begin
      gpio_in <= (sel == SEL_PORT) & pad_sync;
      host_in <= (sel == SEL_HOST) & pad_sync;
      ser_in <= (sel == SEL_SERIAL) & pad_sync;
    end
  end
endmodule : pefs_pin_cell
`default_nettype wire

// ### design/pefs_top.sv
// Function select registers and pad routing for port E pins 24..16
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Selector registers are 16-bit read/write.
// - Top register bits 15..2 read zero.
// - Pin 24: port, host data 15, serial1_clear_to_send.
// - Pin 23: port, host data 14, serial1_request_to_send.
// - Pin 22: port, host data 13, serial0_clear_to_send.
// - Pin 21: port, host data 12, serial0_request_to_send.
// - Pin 20: port, host data 11, serial1_clock.
// - Pin 19: port, host data 10, serial1_receive.
// - Pin 18: port, host data 9, serial1_transmit.
// - Pin 17: port, host data 8, serial0_clock.
// - Pin 16: port, host data 7, serial0_receive.
// - Normal boot: all selectors reset to port.
// - Host boot: selectors start as host data.
// - Direction bits act only in port mode.
// - Direction one drives, zero listens.
module pefs_top
  import pefs_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [pefs_pkg::ADDR_W-1:0] addr,
  input wire logic [pefs_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [pefs_pkg::DATA_W-1:0] rd_data,
  input wire logic host_boot_strap,
  input wire logic [pefs_pkg::NPINS-1:0] pad_in,
  output logic [pefs_pkg::NPINS-1:0] pad_out,
  output logic [pefs_pkg::NPINS-1:0] pad_oe_n,
  input wire logic [pefs_pkg::NPINS-1:0] gpio_out,
  output logic [pefs_pkg::NPINS-1:0] gpio_in,
  input wire logic [pefs_pkg::NPINS-1:0] host_data_out,
  input wire logic [pefs_pkg::NPINS-1:0] host_data_oe,
  output logic [pefs_pkg::NPINS-1:0] host_data_in,
  input wire logic [pefs_pkg::NPINS-1:0] serial_out,
  input wire logic [pefs_pkg::NPINS-1:0] serial_oe,
  output logic [pefs_pkg::NPINS-1:0] serial_in,
  output logic init_done
);
  import pefs_pkg::*;

  // Register map seen by software:
  //   OFF_TOP_SEL  pin 24 selector in bits 1:0, the rest reads zero
  //   OFF_HIGH_SEL pins 23..16 selectors, two bits per pin
  //   OFF_DIR      direction bits for pins 24..16 in bits 8:0
  // Any other offset reads zero and swallows writes.
  // Selector for pin 24
  logic [DATA_W-1:0] port_e_top_pin_function_select;
  // Selectors for pins 23..16
  logic [DATA_W-1:0] port_e_high_pins_function_select;
  // Direction bits for pins 24..16
  logic [DATA_W-1:0] port_e_high_direction;
  // Start-up sequencer
  pefs_state_t state;
  pefs_state_t next_state;
  // Synchronised pads and strap
  logic [SYNC_W-1:0] sync_bus;
  logic [NPINS-1:0] pad_sync;
  logic boot_sync;
  // Per-pin selector codes
  logic [SEL_W-1:0] pin_sel [NPINS];
  // Decoded strobes
  logic wr_top;
  logic wr_high;
  logic wr_dir;

  // Keep the old field wherever software writes the banned code
  // Storing it would leave a pad with no defined owner; keeping the
  // old code costs a little logic but means no field ever reads 11.
  // Legal fields of the same write still take effect.
  function automatic logic [DATA_W-1:0] merge_sel(
    input logic [DATA_W-1:0] old_val,
    input logic [DATA_W-1:0] new_val
  );
    logic [DATA_W-1:0] res;
    res = new_val;
    for (int f = 0; f < NFIELDS; f++)
    begin
      if (new_val[f*SEL_W +: SEL_W] == SEL_BAD)
      begin
        res[f*SEL_W +: SEL_W] = old_val[f*SEL_W +: SEL_W];
      end
    end
    return res;
  endfunction : merge_sel

  // Pads and strap come from outside and pass two flops
  // The strap shares the synchroniser so it lines up with the pads;
  // the two-cycle lag is why the sequencer waits before loading.
  pefs_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in({host_boot_strap, pad_in}),
    .sync_out(sync_bus)
  );
  assign pad_sync = sync_bus[NPINS-1:0];
  assign boot_sync = sync_bus[NPINS];

  // Writes only count once the strap has been applied
  // A write during start-up is dropped, not delayed: software must
  // wait for init_done before it programs the mux.
  assign wr_top = wr_en && (state == ST_RUN) && (addr == OFF_TOP_SEL);
  assign wr_high = wr_en && (state == ST_RUN) && (addr == OFF_HIGH_SEL);
  assign wr_dir = wr_en && (state == ST_RUN) && (addr == OFF_DIR);

  // Next step of the start-up sequence
  always_comb
  begin
    case (state)
      // First edge after release: strap enters the first flop
      ST_WAIT0: next_state = ST_WAIT1;
      // Second edge: strap reaches the second flop
      ST_WAIT1: next_state = ST_LOAD;
      // Boot codes land on this edge
      ST_LOAD: next_state = ST_RUN;
      // Normal operation until the next reset
      ST_RUN: next_state = ST_RUN;
      // Unused codes restart the sequence
      default: next_state = ST_WAIT0;
    endcase
  end

  // Sequencer waits for the strap to clear the synchroniser
  // A reset in mid-run repeats the whole capture
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= ST_WAIT0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Flag for software and peripherals that the mux is live
  // Raised on the edge that loads the boot codes, so the first cycle
  // with init_done high already accepts writes
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // Nothing is live until the strap has been applied
      init_done <= 1'b0;
    end
    else
    begin
      init_done <= (next_state == ST_RUN);
    end
  end

  // Pin 24 selector; upper bits are not stored
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      port_e_top_pin_function_select <= TOP_SEL_RST;
    end
    else if (state == ST_LOAD)
    begin
      // The strap is caught after release, never under reset
      if (boot_sync)
      begin
        port_e_top_pin_function_select <= TOP_SEL_BOOT;
      end
      // Without the strap the reset value already selects the port
    end
    else if (wr_top)
    begin
      // Software write; only the two low bits are stored
      port_e_top_pin_function_select <= merge_sel(
        port_e_top_pin_function_select,
        wr_data & TOP_SEL_MASK);
    end
  end

  // Pins 23..16 selectors
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      port_e_high_pins_function_select <= HIGH_SEL_RST;
    end
    else if (state == ST_LOAD)
    begin
      if (boot_sync)
      begin
        port_e_high_pins_function_select <= HIGH_SEL_BOOT;
      end
      // Without the strap every pin stays a port
    end
    else if (wr_high)
    begin
      // Software write of all eight fields at once
      port_e_high_pins_function_select <= merge_sel(
        port_e_high_pins_function_select,
        wr_data & HIGH_SEL_MASK);
    end
  end

  // Direction bits; the pin cells consult them only in port mode
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // Every pin starts as an input
      port_e_high_direction <= DIR_RST;
    end
    else if (wr_dir)
    begin
      // Reserved bits 15..9 are forced to zero
      port_e_high_direction <= wr_data & DIR_MASK;
    end
  end

  // Read data stands for one cycle after the strobe, else zero
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_data <= READ_IDLE;
    end
    else if (rd_en)
    begin
      case (addr)
        // Pin 24 selector; bits 15..2 are not stored and read zero
        OFF_TOP_SEL: rd_data <= port_e_top_pin_function_select;
        // All eight selectors for pins 23..16
        OFF_HIGH_SEL: rd_data <= port_e_high_pins_function_select;
        // Direction bits; bits 15..9 read zero
        OFF_DIR: rd_data <= port_e_high_direction;
        default: rd_data <= READ_IDLE;
      endcase
    end
    else
    begin
      // Zero between reads, so a stale word is never taken for data
      rd_data <= READ_IDLE;
    end
  end

  // One routing cell per pad; pin 24 takes its code from the top register
  generate
    for (genvar i = 0; i < NPINS; i++)
    begin : g_pin
      if (i == TOP_PIN_IDX)
      begin : g_top
        // Pin 24 has a register of its own; its serial function,
        // serial1_clear_to_send, is input only
        assign pin_sel[i] = port_e_top_pin_function_select[SEL_W-1:0];
      end
      else
      begin : g_high
        // Pins 23..16: ..by field position
        assign pin_sel[i] =
          port_e_high_pins_function_select[i*SEL_W +: SEL_W];
      end

      // Each cell registers its pad outputs so every top output comes
      // straight from a flop; the price is one cycle of routing lag
      pefs_pin_cell #(
        .SER_CAN_DRIVE(SER_DRIVE_MASK[i])
      ) u_cell (
        .clk(clk),
        .arst_n(arst_n),
        .sel(pin_sel[i]),
        .dir(port_e_high_direction[i]),
        .pad_sync(pad_sync[i]),
        .gpio_out(gpio_out[i]),
        .host_out(host_data_out[i]),
        .host_oe(host_data_oe[i]),
        .ser_out(serial_out[i]),
        .ser_oe(serial_oe[i]),
        .pad_out(pad_out[i]),
        .pad_oe_n(pad_oe_n[i]),
        .gpio_in(gpio_in[i]),
        .host_in(host_data_in[i]),
        .ser_in(serial_in[i])
      );
    end
  endgenerate

  // Functions per pin (index i is pin 16+i), code 01 is host data 7+i:
  //   pin 24 bits 1:0 of top: serial1_clear_to_send, input only
  //   pin 23 bits 15:14: serial1_request_to_send, drives
  //   pin 22 bits 13:12: serial0_clear_to_send, input only
  //   pin 21 bits 11:10: serial0_request_to_send, drives
  //   pin 20 bits 9:8: serial1_clock, drives
  //   pin 19 bits 7:6: serial1_receive, input only
  //   pin 18 bits 5:4: serial1_transmit, drives
  //   pin 17 bits 3:2: serial0_clock, drives
  //   pin 16 bits 1:0: serial0_receive, input only
  // SER_DRIVE_MASK carries the drives column.
endmodule : pefs_top
`default_nettype wire

// ### verification/pefs_monitor.sv
// Checker for the upper port E pin mux ports
`timescale 1ns/1ps
`default_nettype none
module pefs_monitor
  import pefs_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [pefs_pkg::ADDR_W-1:0] addr,
  input wire logic [pefs_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [pefs_pkg::DATA_W-1:0] rd_data,
  input wire logic host_boot_strap,
  input wire logic [pefs_pkg::NPINS-1:0] pad_out,
  input wire logic [pefs_pkg::NPINS-1:0] pad_oe_n,
  input wire logic [pefs_pkg::NPINS-1:0] gpio_out,
  input wire logic [pefs_pkg::NPINS-1:0] gpio_in,
  input wire logic [pefs_pkg::NPINS-1:0] host_data_out,
  input wire logic [pefs_pkg::NPINS-1:0] host_data_oe,
  input wire logic [pefs_pkg::NPINS-1:0] host_data_in,
  input wire logic [pefs_pkg::NPINS-1:0] serial_out,
  input wire logic [pefs_pkg::NPINS-1:0] serial_oe,
  input wire logic [pefs_pkg::NPINS-1:0] serial_in,
  input wire logic init_done
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  logic [17:0] m_sel; // Mirrored selectors, pin 24 on top
  logic [NPINS-1:0] m_dir; // Mirrored direction bits
  logic [SEL_W-1:0] c; // Code of the pin under scan
  logic [NPINS-1:0] pm, hm, sm, e_oe_n, e_drv;
  logic [DATA_W-1:0] e_rd; // Expected read word
  logic [1:0] m_cnt; // Edges seen since reset release
  // Mirror takes the strap on the third edge after release, as the mux
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      {m_sel, m_dir, m_cnt} <= '0;
    else if (!init_done)
    begin
      if (m_cnt == 2'h2)
        m_sel <= host_boot_strap ? {TOP_SEL_BOOT[1:0], HIGH_SEL_BOOT} : '0;
      m_cnt <= m_cnt + 2'h1;
    end
    else if (wr_en)
    begin
      // A field written as 11 keeps its old code
      for (int i = 0; i < NFIELDS; i++)
        if (addr == OFF_HIGH_SEL && wr_data[2*i+:2] != SEL_BAD)
          m_sel[2*i+:2] <= wr_data[2*i+:2];
      if (addr == OFF_TOP_SEL && wr_data[1:0] != SEL_BAD)
        m_sel[17:16] <= wr_data[1:0];
      if (addr == OFF_DIR)
        m_dir <= wr_data[NPINS-1:0];
    end
  // Expected pad routing and read word
  always_comb
  begin
    for (int i = 0; i < NPINS; i++)
    begin
      c = m_sel[2*i+:2];
      pm[i] = c == SEL_PORT;
      hm[i] = c == SEL_HOST;
      sm[i] = c == SEL_SERIAL;
      e_oe_n[i] = pm[i] ? !m_dir[i] : hm[i] ? !host_data_oe[i] :
        !(sm[i] && serial_oe[i] && SER_DRIVE_MASK[i]);
      e_drv[i] = !e_oe_n[i] && (pm[i] ? gpio_out[i] :
        hm[i] ? host_data_out[i] : serial_out[i]);
    end
    e_rd = READ_IDLE;
    if (addr == OFF_TOP_SEL)
      e_rd = {14'h0000, m_sel[17:16]};
    if (addr == OFF_HIGH_SEL)
      e_rd = m_sel[15:0];
    if (addr == OFF_DIR)
      e_rd = {7'h00, m_dir};
  end
  sequence s_top_read;
    rd_en && addr == OFF_TOP_SEL;
  endsequence
  property p_rd_idle; !rd_en |=> rd_data == READ_IDLE; endproperty
  property p_rd; rd_en |=> rd_data == $past(e_rd); endproperty
  property p_rd_rsv; s_top_read |=> rd_data[15:2] == 14'h0000; endproperty
  property p_oe; pad_oe_n == $past(e_oe_n); endproperty
  property p_out; (pad_out & ~pad_oe_n) == $past(e_drv); endproperty
  property p_gate; ((gpio_in & ~$past(pm)) | (host_data_in & ~$past(hm))
    | (serial_in & ~$past(sm))) == '0; endproperty
  property p_boot_oe; !init_done |-> &pad_oe_n; endproperty
  property p_done; init_done |=> init_done [*3]; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  a_rd: assert property (p_rd) else $error("read data wrong");
  a_rd_rsv: assert property (p_rd_rsv) else $error("reserved set");
  a_oe: assert property (p_oe) else $error("pad enable wrong");
  a_out: assert property (p_out) else $error("pad value wrong");
  a_gate: assert property (p_gate) else $error("input leaks");
  a_boot_oe: assert property (p_boot_oe) else $error("early drive");
  a_done: assert property (p_done) else $error("init dropped");
endmodule : pefs_monitor
`default_nettype wire

// ### verification/pefs_peer.sv
// Host interface and serial unit stand-in on the pad mux far side
`timescale 1ns/1ps
`default_nettype none
module pefs_peer
  import pefs_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic peer_en,
  output logic [pefs_pkg::NPINS-1:0] host_data_out,
  output logic [pefs_pkg::NPINS-1:0] host_data_oe,
  output logic [pefs_pkg::NPINS-1:0] serial_out,
  output logic [pefs_pkg::NPINS-1:0] serial_oe
);
  // Idle data toggles so a leak of a released line is seen
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      {host_data_out, serial_out} <= '0;
    else if (peer_en)
      {host_data_out, serial_out} <= {9'h155, 9'h0f0};
    else
      {host_data_out, serial_out} <= ~{host_data_out, serial_out};
  // Serial unit asks to drive every pin, input-only ones too
  assign host_data_oe = {NPINS{peer_en}};
  assign serial_oe = {NPINS{peer_en}};
endmodule : pefs_peer
`default_nettype wire

// ### verification/pefs_top_test.sv
// Self-checking bench for the upper port E pin mux
`timescale 1ns/1ps
`default_nettype none
module pefs_top_test;
  import pefs_pkg::*;
  logic clk, arst_n, wr_en, rd_en, host_boot_strap, peer_en, init_done;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data, rd_data;
  logic [NPINS-1:0] pad_in, pad_out, pad_oe_n, gpio_out, gpio_in;
  logic [NPINS-1:0] host_data_out, host_data_oe, host_data_in;
  logic [NPINS-1:0] serial_out, serial_oe, serial_in;
  int failures, total_checks, cycles;
  // Expected enables and driven values for port, host, serial
  logic [NPINS-1:0] exp_oe_n [3] = '{9'h000, 9'h000, ~SER_DRIVE_MASK};
  logic [NPINS-1:0] exp_out [3] = '{9'h1aa, 9'h155,
    9'h0f0 & SER_DRIVE_MASK};
  pefs_top pefs_top_inst (.*);
  pefs_peer pefs_peer_inst (.*);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      failures++;
      summarize();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Strobe then one idle edge, so no strobe is set twice at one edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rd_data, e);
    @(posedge clk);
  endtask : rd
  task automatic boot(input logic s);
    arst_n <= 1'b0;
    host_boot_strap <= s;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (5) @(posedge clk);
  endtask : boot
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  initial
  begin
    {arst_n, wr_en, rd_en, host_boot_strap, peer_en} = '0;
    {addr, wr_data, pad_in, gpio_out} = '0;
    {failures, total_checks, cycles} = '0;
    boot(1'b0);
    rd(OFF_TOP_SEL, 16'h0000);
    rd(OFF_HIGH_SEL, 16'h0000);
    #1 chk(16'(pad_oe_n), 16'h01ff);
    @(posedge clk);
    $display("test normal boot done");
    // Prohibited fields keep old codes, others take effect
    wr(OFF_HIGH_SEL, 16'h5555);
    rd(OFF_HIGH_SEL, 16'h5555);
    wr(OFF_HIGH_SEL, 16'hfa5a);
    rd(OFF_HIGH_SEL, 16'h5a5a);
    wr(OFF_TOP_SEL, 16'hfffe);
    rd(OFF_TOP_SEL, 16'h0002);
    wr(OFF_TOP_SEL, 16'hffff);
    rd(OFF_TOP_SEL, 16'h0002);
    rd(4'h6, 16'h0000);
    $display("test registers done");
    // Codes 00, 01 and 10 on every pin; direction stays all ones
    peer_en <= 1'b1;
    gpio_out <= 9'h1aa;
    pad_in <= 9'h123;
    wr(OFF_DIR, 16'h01ff);
    for (int c = 0; c < 3; c++)
    begin
      wr(OFF_HIGH_SEL, {8{c[1:0]}});
      wr(OFF_TOP_SEL, 16'(c));
      @(posedge clk);
      #1 chk(16'(pad_oe_n), 16'(exp_oe_n[c]));
      chk(16'(pad_out & ~pad_oe_n), 16'(exp_out[c]));
      chk(16'(gpio_in), c == 0 ? 16'h0123 : 16'h0000);
      chk(16'(host_data_in), c == 1 ? 16'h0123 : 16'h0000);
      chk(16'(serial_in), c == 2 ? 16'h0123 : 16'h0000);
      @(posedge clk);
    end
    wr(OFF_HIGH_SEL, 16'h0000);
    wr(OFF_TOP_SEL, 16'h0000);
    wr(OFF_DIR, 16'h0000);
    #1 chk(16'(pad_oe_n), 16'h01ff);
    @(posedge clk);
    $display("test routing done");
    // Host boot starts every pin as a host data line
    peer_en <= 1'b0;
    pad_in <= 9'h000;
    boot(1'b1);
    rd(OFF_TOP_SEL, TOP_SEL_BOOT);
    rd(OFF_HIGH_SEL, HIGH_SEL_BOOT);
    // Host now drives: every pad must carry its host data line
    peer_en <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(16'(pad_oe_n), 16'h0000);
    chk(16'(pad_out & ~pad_oe_n), 16'h0155);
    $display("test host boot done");
    summarize();
  end
endmodule : pefs_top_test
bind pefs_top pefs_monitor pefs_monitor_inst (.*);
`default_nettype wire
